// >>> hdl/acc_regs.svh
// register map, field positions and reset values of the comparator control
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// register offsets
`define ACC_ADDR_W 2
`define ACC_OFF_SC0 2'h0
`define ACC_OFF_SC1 2'h1
`define ACC_OFF_SYS 2'h2

// status and control fields
`define ACC_BIT_ENABLE 7
`define ACC_BIT_REFSEL 6
`define ACC_BIT_FLAG 5
`define ACC_BIT_IE 4
`define ACC_BIT_LIVE 3
`define ACC_BIT_OPE 2
`define ACC_MOD_HI 1
`define ACC_MOD_LO 0
`define ACC_SC_WMASK 8'hd7
`define ACC_SC_RESET 8'h00

// system register fields
`define ACC_BIT_CLKGATE 0
`define ACC_BIT_ROUTE0 1
`define ACC_SYS_WMASK 8'h07
`define ACC_SYS_RESET 8'h01

`endif

// >>> hdl/acc_pkg.sv
// types of the comparator control block
package acc_pkg;

  localparam int ACC_NUM_CMP = 2;

  typedef enum logic [3:0] {
    ACC_PWR_RUN = 4'b0001,
    ACC_PWR_WAIT = 4'b0010,
    ACC_PWR_STOP_LIGHT = 4'b0100,
    ACC_PWR_STOP_DEEP = 4'b1000
  } acc_pwr_e;

  typedef enum logic [1:0] {
    ACC_MOD_FALL = 2'b00,
    ACC_MOD_RISE = 2'b01,
    ACC_MOD_FALL_ALT = 2'b10,
    ACC_MOD_BOTH = 2'b11
  } acc_mod_e;

  typedef struct packed {
    acc_pwr_e pwr;
    logic [ACC_NUM_CMP-1:0][7:0] ctrl;
    logic [7:0] sys;
    logic [7:0] rdata;
  } acc_state_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } acc_edge_s;

endpackage

// >>> hdl/acc_edge.sv
// synchroniser and edge detector for one comparator output
`timescale 1ns/1ps

module acc_edge (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // control
  input wire logic adv_in,
  input wire logic clr_in,
  // comparator output, asynchronous
  input wire logic raw_in,
  // results
  output logic live_out,
  output logic rise_out,
  output logic fall_out
);

  acc_pkg::acc_edge_s q;
  acc_pkg::acc_edge_s next_q;

  // s1 feeds only s2; everything else looks at s2 and prev
  always_comb begin
    next_q = q;
    if (clr_in) begin
      next_q = '0;
    end else if (adv_in) begin
      next_q.s1 = raw_in;
      next_q.s2 = q.s1;
      next_q.prev = q.s2;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= next_q;
    end
  end

  // a frozen chain keeps its pending edge; the owner counts it once
  assign live_out = q.s2;
  assign rise_out = q.s2 & ~q.prev;
  assign fall_out = ~q.s2 & q.prev;

endmodule

// >>> hdl/acc_ctrl.sv
// control and status logic of a pair of analog comparators
`timescale 1ns/1ps
`include "acc_regs.svh"


module acc_ctrl (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  // register port
  input wire logic [`ACC_ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // power modes
  input wire logic WAIT_IN,
  input wire logic STOP_LIGHT_IN,
  input wire logic STOP_DEEP_IN,
  // analog comparators
  input wire logic [acc_pkg::ACC_NUM_CMP-1:0] CMP_RAW_IN,
  output logic [acc_pkg::ACC_NUM_CMP-1:0] CMP_EN_OUT,
  output logic [acc_pkg::ACC_NUM_CMP-1:0] CMP_REF_SEL_OUT,
  // digital output pins
  output logic [acc_pkg::ACC_NUM_CMP-1:0] DOUT_OUT,
  output logic [acc_pkg::ACC_NUM_CMP-1:0] DOUT_OE_OUT,
  // timer capture channel zero
  output logic [acc_pkg::ACC_NUM_CMP-1:0] TIMER_CAP_OUT,
  output logic [acc_pkg::ACC_NUM_CMP-1:0] TIMER_PIN_BLOCK_OUT,
  // shared interrupt request
  output logic IRQ_OUT
);

  localparam int N = acc_pkg::ACC_NUM_CMP;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  acc_pkg::acc_state_s q;
  acc_pkg::acc_state_s next_q;

  logic [N-1:0] live;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] event_hit;
  logic [N-1:0] wr_sc;
  logic [N-1:0] enabled;
  logic [N-1:0] adv;
  logic [N-1:0] clr;
  logic stopped;
  logic deep;
  logic clk_on;
  logic run;

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------

  assign stopped = (q.pwr == acc_pkg::ACC_PWR_STOP_LIGHT) ||
                   (q.pwr == acc_pkg::ACC_PWR_STOP_DEEP);
  assign deep = (q.pwr == acc_pkg::ACC_PWR_STOP_DEEP);
  assign clk_on = q.sys[`ACC_BIT_CLKGATE];
  // wait does not stop the block
  assign run = clk_on && !stopped;

  // ----------------------------------------------------------------
  // per comparator event detection
  // ----------------------------------------------------------------

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_cmp
      assign enabled[g] = q.ctrl[g][`ACC_BIT_ENABLE];
      // disabled or in deep stop: chain cleared so live reads zero
      assign clr[g] = !enabled[g] || deep;
      assign adv[g] = run;

      acc_edge u_edge (
        .clk_in(REF_CLK_IN),
        .rst_n_in(NRST_IN),
        .ce_in(CE_IN),
        .adv_in(adv[g]),
        .clr_in(clr[g]),
        .raw_in(CMP_RAW_IN[g]),
        .live_out(live[g]),
        .rise_out(rise[g]),
        .fall_out(fall[g])
      );

      always_comb begin
        event_hit[g] = 1'b0;
        if (run && enabled[g]) begin
          case (acc_pkg::acc_mod_e'(q.ctrl[g][`ACC_MOD_HI:`ACC_MOD_LO]))
            acc_pkg::ACC_MOD_FALL: event_hit[g] = fall[g];
            acc_pkg::ACC_MOD_RISE: event_hit[g] = rise[g];
            acc_pkg::ACC_MOD_FALL_ALT: event_hit[g] = fall[g];
            acc_pkg::ACC_MOD_BOTH: event_hit[g] = rise[g] | fall[g];
            default: event_hit[g] = 1'b0;
          endcase
        end
      end

      assign wr_sc[g] = WR_IN && (ADDR_IN == `ACC_ADDR_W'(g));

      // analog side is off in every stop mode
      assign CMP_EN_OUT[g] = enabled[g] && !stopped;
      // comparator gives high when non-inverting input is larger
      assign CMP_REF_SEL_OUT[g] = q.ctrl[g][`ACC_BIT_REFSEL];
      assign DOUT_OE_OUT[g] = q.ctrl[g][`ACC_BIT_OPE];
      assign DOUT_OUT[g] = q.ctrl[g][`ACC_BIT_OPE] & live[g];
      assign TIMER_PIN_BLOCK_OUT[g] =
        q.sys[`ACC_BIT_ROUTE0 + g];
      assign TIMER_CAP_OUT[g] =
        q.sys[`ACC_BIT_ROUTE0 + g] & live[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  always_comb begin
    next_q = q;

    // deep stop outranks light stop, which outranks wait
    if (STOP_DEEP_IN) begin
      next_q.pwr = acc_pkg::ACC_PWR_STOP_DEEP;
    end else if (STOP_LIGHT_IN) begin
      next_q.pwr = acc_pkg::ACC_PWR_STOP_LIGHT;
    end else if (WAIT_IN) begin
      next_q.pwr = acc_pkg::ACC_PWR_WAIT;
    end else begin
      next_q.pwr = acc_pkg::ACC_PWR_RUN;
    end

    for (int i = 0; i < N; i++) begin
      if (deep) begin
        next_q.ctrl[i] = `ACC_SC_RESET;
      end else if (run) begin
        // writes reach the register only while its clock runs
        if (wr_sc[i]) begin
          next_q.ctrl[i] = (WDATA_IN & `ACC_SC_WMASK) |
                           (q.ctrl[i] & ~`ACC_SC_WMASK);
        end
        // flag: write one clears, zero keeps, event wins
        next_q.ctrl[i][`ACC_BIT_FLAG] = event_hit[i] ||
          (q.ctrl[i][`ACC_BIT_FLAG] &&
           !(wr_sc[i] && WDATA_IN[`ACC_BIT_FLAG]));
      end
      // live bit is never stored; it reads from the synchroniser
      next_q.ctrl[i][`ACC_BIT_LIVE] = 1'b0;
    end

    // system register sits outside the gated clock
    if (WR_IN && ADDR_IN == `ACC_OFF_SYS) begin
      next_q.sys = WDATA_IN & `ACC_SYS_WMASK;
    end

    next_q.rdata = 8'h00;
    if (RD_IN) begin
      if (ADDR_IN == `ACC_OFF_SYS) begin
        next_q.rdata = q.sys;
      end else if (ADDR_IN < `ACC_ADDR_W'(N)) begin
        for (int i = 0; i < N; i++) begin
          if (ADDR_IN == `ACC_ADDR_W'(i)) begin
            next_q.rdata = q.ctrl[i];
            next_q.rdata[`ACC_BIT_LIVE] = live[i] & enabled[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // a reset during light stop lands here and restores reset state
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      q.pwr <= acc_pkg::ACC_PWR_RUN;
      q.ctrl <= {N{`ACC_SC_RESET}};
      q.sys <= `ACC_SYS_RESET;
      q.rdata <= 8'h00;
    end else if (CE_IN) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  always_comb begin
    IRQ_OUT = 1'b0;
    for (int i = 0; i < N; i++) begin
      IRQ_OUT = IRQ_OUT |
        (q.ctrl[i][`ACC_BIT_FLAG] & q.ctrl[i][`ACC_BIT_IE]);
    end
  end

  assign RDATA_OUT = q.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  a_flag_set_wins: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && event_hit[0] && wr_sc[0] && WDATA_IN[`ACC_BIT_FLAG]
    |=> q.ctrl[0][`ACC_BIT_FLAG])
    else $error("event lost against flag clear");

  a_flag_one_clears: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && run && !event_hit[0] && wr_sc[0] &&
    WDATA_IN[`ACC_BIT_FLAG]
    |=> !q.ctrl[0][`ACC_BIT_FLAG])
    else $error("flag not cleared by write of one");

  a_flag_zero_keeps: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && !deep && wr_sc[1] && !WDATA_IN[`ACC_BIT_FLAG] &&
    q.ctrl[1][`ACC_BIT_FLAG]
    |=> q.ctrl[1][`ACC_BIT_FLAG])
    else $error("flag lost on write of zero");

  a_irq_follows: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && event_hit[0] && q.ctrl[0][`ACC_BIT_IE] && !wr_sc[0]
    |=> IRQ_OUT)
    else $error("interrupt line disagrees with flags");

  a_live_disabled: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && RD_IN && ADDR_IN == `ACC_OFF_SC0 && !enabled[0]
    |=> RDATA_OUT[`ACC_BIT_LIVE] == 1'b0)
    else $error("live bit read nonzero while disabled");

  a_rise_sets: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && run && enabled[0] && rise[0] && !deep &&
    q.ctrl[0][`ACC_MOD_HI:`ACC_MOD_LO] == 2'b01
    |=> q.ctrl[0][`ACC_BIT_FLAG])
    else $error("rising edge did not set flag");

  a_fall_ignored: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && !q.ctrl[0][`ACC_BIT_FLAG] && !(wr_sc[0] || deep) &&
    q.ctrl[0][`ACC_MOD_HI:`ACC_MOD_LO] == 2'b01 && !rise[0]
    |=> !q.ctrl[0][`ACC_BIT_FLAG])
    else $error("flag set without rising edge");

  a_stop_analog_off: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && (STOP_LIGHT_IN || STOP_DEEP_IN) |=> CMP_EN_OUT == '0)
    else $error("comparator enabled in stop");

  a_light_hold: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    q.pwr == acc_pkg::ACC_PWR_STOP_LIGHT ##1
    q.pwr == acc_pkg::ACC_PWR_STOP_LIGHT |-> $stable(q.ctrl))
    else $error("registers changed in light stop");

  a_deep_wipe: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && deep |=> q.ctrl == {N{`ACC_SC_RESET}} ##1 live == '0)
    else $error("deep stop did not restore reset state");

  a_pin_off: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    !q.ctrl[0][`ACC_BIT_OPE] |-> !DOUT_OE_OUT[0] && !DOUT_OUT[0])
    else $error("pin carries output while disabled");

  a_gate_freeze: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && !clk_on && !deep && !STOP_DEEP_IN ##1 !deep
    |-> $stable(q.ctrl))
    else $error("gated comparator state changed");

  a_enable_on: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && run && wr_sc[0] && WDATA_IN[`ACC_BIT_ENABLE] &&
    !STOP_LIGHT_IN && !STOP_DEEP_IN
    |=> CMP_EN_OUT[0])
    else $error("enable write did not start comparator");

  a_ref_select: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && run && wr_sc[1]
    |=> CMP_REF_SEL_OUT[1] == $past(WDATA_IN[`ACC_BIT_REFSEL]))
    else $error("reference select does not follow write");

  a_live_reads: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && RD_IN && ADDR_IN == `ACC_OFF_SC1 && enabled[1]
    |=> RDATA_OUT[`ACC_BIT_LIVE] == $past(live[1]))
    else $error("live bit does not show comparator output");

  a_fall_sets: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && run && enabled[1] && fall[1] &&
    q.ctrl[1][`ACC_MOD_HI:`ACC_MOD_LO] != 2'b01
    |=> q.ctrl[1][`ACC_BIT_FLAG])
    else $error("falling edge did not set flag");

  a_wait_active: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    q.pwr == acc_pkg::ACC_PWR_WAIT && enabled[1]
    |-> CMP_EN_OUT[1] && (run == clk_on))
    else $error("comparator stopped in wait mode");

  a_route_cap: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    q.sys[`ACC_BIT_ROUTE0 + 1]
    |-> TIMER_PIN_BLOCK_OUT[1] && TIMER_CAP_OUT[1] == live[1])
    else $error("routed output missing at capture channel");

  a_irq_shared: assert property (
    @(posedge REF_CLK_IN) disable iff (!NRST_IN)
    CE_IN && event_hit[1] && q.ctrl[1][`ACC_BIT_IE] && !wr_sc[1]
    |=> IRQ_OUT)
    else $error("second comparator event missed shared line");

endmodule

// >>> test/acc_src.sv
// behavioural analog sources and comparator for one channel
`timescale 1ns/1ps

module acc_src (
  // clock
  input wire logic clk_in,
  // control from the block
  input wire logic en_in,
  input wire logic ref_sel_in,
  // input levels as codes
  input wire logic [7:0] pos_in,
  input wire logic [7:0] neg_in,
  input wire logic [7:0] bg_in,
  // comparator decision
  output logic raw_out
);
  logic tog = 1'b0;
  logic [7:0] plus;

  always @(posedge clk_in) begin
    tog <= ~tog;
  end

  // ------------------------------------------------------------
  // decision
  // ------------------------------------------------------------
  assign plus = ref_sel_in ? bg_in : pos_in;
  // powered down it gives no stable answer, so the block must ignore it
  assign raw_out = en_in ? (plus > neg_in) : tog;
endmodule

// >>> test/testbench.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps

module testbench;
  logic REF_CLK_IN = 1'b0;
  logic NRST_IN = 1'b0;
  logic CE_IN = 1'b1;
  logic [1:0] ADDR_IN = 2'h0;
  logic [7:0] WDATA_IN = 8'h00;
  logic WR_IN = 1'b0;
  logic RD_IN = 1'b0;
  logic WAIT_IN = 1'b0;
  logic STOP_LIGHT_IN = 1'b0;
  logic STOP_DEEP_IN = 1'b0;
  logic [7:0] RDATA_OUT;
  logic [1:0] CMP_RAW_IN, CMP_EN_OUT, CMP_REF_SEL_OUT, DOUT_OUT;
  logic [1:0] DOUT_OE_OUT, TIMER_CAP_OUT, TIMER_PIN_BLOCK_OUT;
  logic IRQ_OUT;
  logic [7:0] lv [3] = '{8'h40, 8'h40, 8'h40};
  logic [7:0] exp_q [$];
  logic rd_taken = 1'b0;
  logic f;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #4 REF_CLK_IN = ~REF_CLK_IN;

  acc_ctrl DUT (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .WAIT_IN(WAIT_IN), .STOP_LIGHT_IN(STOP_LIGHT_IN),
    .STOP_DEEP_IN(STOP_DEEP_IN), .CMP_RAW_IN(CMP_RAW_IN),
    .CMP_EN_OUT(CMP_EN_OUT), .CMP_REF_SEL_OUT(CMP_REF_SEL_OUT),
    .DOUT_OUT(DOUT_OUT), .DOUT_OE_OUT(DOUT_OE_OUT),
    .TIMER_CAP_OUT(TIMER_CAP_OUT),
    .TIMER_PIN_BLOCK_OUT(TIMER_PIN_BLOCK_OUT), .IRQ_OUT(IRQ_OUT));

  for (genvar i = 0; i < 2; i++) begin : g_src
    acc_src SRC (.clk_in(REF_CLK_IN), .en_in(CMP_EN_OUT[i]),
      .ref_sel_in(CMP_REF_SEL_OUT[i]), .pos_in(lv[i]), .neg_in(8'h80),
      .bg_in(lv[2]), .raw_out(CMP_RAW_IN[i]));
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge REF_CLK_IN);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge REF_CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    WR_IN <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge REF_CLK_IN);
    exp_q.push_back(e);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    RD_IN <= 1'b0;
  endtask

  // index 2 is the bandgap level; the inverting input sits at 8'h80
  task automatic lvl(input int c, input bit hi);
    @(posedge REF_CLK_IN);
    lv[c] <= hi ? 8'(129 + $urandom_range(100))
                : 8'(127 - $urandom_range(100));
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge REF_CLK_IN) rd_taken <= RD_IN;
  always @(negedge REF_CLK_IN) begin
    if (rd_taken) begin
      if (exp_q.size() == 0) chk(RDATA_OUT, 8'hxx);
      else chk(RDATA_OUT, exp_q.pop_front());
    end
  end

  always @(posedge REF_CLK_IN) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h6978ea9a));
    wt(20);
    NRST_IN <= 1'b1;
    for (int a = 0; a < 4; a++) rd(2'(a), (a == 2) ? 8'h01 : 8'h00);
    @(negedge REF_CLK_IN);
    chk({3'b0, IRQ_OUT, CMP_EN_OUT, DOUT_OE_OUT}, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      lvl(0, 0);
      wr(2'h0, 8'h90 | 8'(m));
      wt(6);
      rd(2'h0, 8'h90 | 8'(m));
      lvl(0, 1);
      wt(6);
      f = (m == 1 || m == 3);
      rd(2'h0, 8'h98 | 8'(m) | {2'b0, f, 5'b0});
      @(negedge REF_CLK_IN) chk({7'b0, IRQ_OUT}, {7'b0, f});
      wr(2'h0, 8'hb0 | 8'(m));
      lvl(0, 0);
      wt(6);
      f = (m != 1);
      wr(2'h0, 8'h90 | 8'(m));
      rd(2'h0, 8'h90 | 8'(m) | {2'b0, f, 5'b0});
      wr(2'h0, 8'h20);
      rd(2'h0, 8'h00);
    end
    $display("test edge modes done");
    lvl(1, 0);
    lvl(2, 1);
    wr(2'h1, 8'h44);
    rd(2'h1, 8'h44);
    @(negedge REF_CLK_IN);
    chk({2'b0, CMP_REF_SEL_OUT, DOUT_OE_OUT, DOUT_OUT}, 8'h28);
    // reference is picked before the comparator is enabled
    wr(2'h1, 8'hc4);
    wt(6);
    rd(2'h1, 8'hcc);
    wr(2'h2, 8'h05);
    @(negedge REF_CLK_IN);
    chk({2'b0, TIMER_PIN_BLOCK_OUT, TIMER_CAP_OUT, DOUT_OUT},
      8'h2a);
    lvl(2, 0);
    wt(6);
    rd(2'h1, 8'he4);
    @(negedge REF_CLK_IN) chk({7'b0, IRQ_OUT}, 8'h00);
    wr(2'h1, 8'hd4);
    @(negedge REF_CLK_IN) chk({7'b0, IRQ_OUT}, 8'h01);
    $display("test pins and route done");
    // comparator 1 stays on through wait, its edge still raises the interrupt
    @(posedge REF_CLK_IN) WAIT_IN <= 1'b1;
    wr(2'h1, 8'hf4);
    lvl(2, 1);
    wt(6);
    lvl(2, 0);
    wt(6);
    @(negedge REF_CLK_IN) chk({7'b0, IRQ_OUT}, 8'h01);
    rd(2'h1, 8'hf4);
    @(posedge REF_CLK_IN) WAIT_IN <= 1'b0;
    $display("test wait done");
    wr(2'h1, 8'hf7);
    lvl(2, 1);
    wt(1);
    // edge reaches the flag on the very edge that the clear lands
    wr(2'h1, 8'hf7);
    rd(2'h1, 8'hff);
    wr(2'h1, 8'hf7);
    wt(2);
    @(posedge REF_CLK_IN) STOP_LIGHT_IN <= 1'b1;
    wt(3);
    @(negedge REF_CLK_IN) chk({6'b0, CMP_EN_OUT}, 8'h00);
    wr(2'h1, 8'h00);
    lvl(2, 0);
    wt(4);
    lvl(2, 1);
    wt(4);
    @(negedge REF_CLK_IN) chk({7'b0, IRQ_OUT}, 8'h00);
    @(posedge REF_CLK_IN) STOP_LIGHT_IN <= 1'b0;
    wt(6);
    rd(2'h1, 8'hdf);
    @(posedge REF_CLK_IN) STOP_DEEP_IN <= 1'b1;
    wt(3);
    @(posedge REF_CLK_IN) STOP_DEEP_IN <= 1'b0;
    wt(3);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h05);
    $display("test stop modes done");
    wr(2'h2, 8'h00);
    wr(2'h0, 8'h80);
    wr(2'h3, 8'hff);
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h2, 8'h01);
    // a write while the clock enable is low is lost
    @(posedge REF_CLK_IN) CE_IN <= 1'b0;
    wr(2'h0, 8'h80);
    @(posedge REF_CLK_IN) CE_IN <= 1'b1;
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h80);
    wr(2'h2, 8'h07);
    // reset arrives while in light stop
    @(posedge REF_CLK_IN) STOP_LIGHT_IN <= 1'b1;
    wt(2);
    @(posedge REF_CLK_IN) NRST_IN <= 1'b0;
    STOP_LIGHT_IN <= 1'b0;
    wt(3);
    @(posedge REF_CLK_IN) NRST_IN <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h01);
    wt(3);
    $display("test clock gate and reset done");
    print_verdict();
  end
endmodule
